// ---- verilog/tbd_touch_baseline.sv ----
/*
 * Touch baseline detector: per-sensor baseline tracking, low-baseline
 * reset, signal and debounced touch state, optional three-frequency median.
 * Assumes one raw-count result per cycle at most from the scan front end,
 * inputs synchronous to CLK, and an APB master for configuration.
 */
// The APB slave port and the register addresses are this design's own decisions.
// Summary of operation
// - inside the noise window, baseline follows raw count through low-pass filter
// - with auto-reset off, raw count above baseline plus noise threshold leaves baseline unchanged
// - raw count below lower window holds baseline and counts a low sample
// - enough consecutive low samples reload baseline with raw count
// - first raw count after reset seeds the baseline directly
// - signal is raw count minus current baseline, drives state decision
// - ON only after debounce consecutive scans at threshold plus hysteresis
// - OFF at threshold minus hysteresis; between limits state is kept
// - auto-reset updates baseline on every scan not in the low zone
// - multi-frequency mode gathers difference counts at three sense frequencies
// - multi-frequency mode feeds the median difference to state logic
`timescale 1ns/1ps

module tbd_touch_baseline #(
    parameter int NUM_SENSORS = 8,
    parameter int RAW_W = 16
) (
    input wire logic CLK,
    input wire logic RESETN,
    // scan front end
    input wire logic SCAN_VALID,
    input wire logic [$clog2(NUM_SENSORS)-1:0] SCAN_SENSOR,
    input wire logic [1:0] SCAN_FREQ,
    input wire logic [RAW_W-1:0] SCAN_RAW,
    // processed result
    output logic RESULT_VALID,
    output logic [$clog2(NUM_SENSORS)-1:0] RESULT_SENSOR,
    output logic signed [RAW_W:0] RESULT_SIGNAL,
    output logic [NUM_SENSORS-1:0] SENSOR_ON,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    localparam int SW = $clog2(NUM_SENSORS);
    localparam int SLOTS = NUM_SENSORS * tbd_pkg::NUM_FREQ;
    localparam int IW = $clog2(SLOTS);
    localparam int EW = RAW_W + 2;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [IW-1:0] slot_of(input logic [SW-1:0] s, input logic [1:0] f);
        slot_of = IW'(s * tbd_pkg::NUM_FREQ + f);
    endfunction : slot_of

    function automatic logic signed [EW-1:0] ext(input logic [RAW_W-1:0] v);
        ext = signed'({2'b00, v});
    endfunction : ext

    function automatic logic signed [EW-1:0] median3(
        input logic signed [EW-1:0] a,
        input logic signed [EW-1:0] b,
        input logic signed [EW-1:0] c
    );
        if ((a >= b && a <= c) || (a <= b && a >= c))
            median3 = a;
        else if ((b >= a && b <= c) || (b <= a && b >= c))
            median3 = b;
        else
            median3 = c;
    endfunction : median3

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [RAW_W-1:0] finger_th_reg;
    logic [RAW_W-1:0] hyst_reg;
    logic [RAW_W-1:0] noise_th_reg;
    logic [RAW_W-1:0] neg_noise_th_reg;
    logic [7:0] low_reset_cnt_reg;
    logic [7:0] debounce_reg;
    logic [SW-1:0] sel_sensor_reg;
    logic [1:0] sel_freq_reg;
    logic [31:0] prdata_reg;

    // ------------------------------------------------------------------
    // per-sensor state
    // ------------------------------------------------------------------
    logic [RAW_W-1:0] baseline_mem [SLOTS];
    logic [SLOTS-1:0] seeded_reg;
    logic [7:0] low_run_mem [SLOTS];
    logic signed [EW-1:0] diff_mem [SLOTS];
    logic [7:0] deb_cnt_mem [NUM_SENSORS];
    logic [NUM_SENSORS-1:0] on_reg;
    logic result_valid_reg;
    logic [SW-1:0] result_sensor_reg;
    logic signed [RAW_W:0] result_signal_reg;

    // ------------------------------------------------------------------
    // scan sample classification
    // ------------------------------------------------------------------
    logic auto_reset;
    logic multi_freq;
    logic [tbd_pkg::CTRL_SHIFT_W-1:0] shift_amt;
    logic [IW-1:0] slot;
    logic scan_take;
    logic [RAW_W-1:0] bl;
    logic signed [EW-1:0] diff;
    logic signed [EW-1:0] filt_step;
    tbd_pkg::tbd_zone_e zone;
    logic [7:0] low_run_inc;
    logic low_reload;

    assign auto_reset = ctrl_reg[tbd_pkg::CTRL_AUTO_RESET_BIT];
    assign multi_freq = ctrl_reg[tbd_pkg::CTRL_MULTI_FREQ_BIT];
    assign shift_amt = ctrl_reg[tbd_pkg::CTRL_SHIFT_LSB +: tbd_pkg::CTRL_SHIFT_W];
    // single-frequency mode only accepts the first sense frequency
    assign scan_take = SCAN_VALID
        && (SCAN_FREQ == 2'd0 || (multi_freq && SCAN_FREQ < 2'd3));
    assign slot = slot_of(SCAN_SENSOR, SCAN_FREQ);
    assign bl = baseline_mem[slot];
    assign diff = ext(SCAN_RAW) - ext(bl);
    assign filt_step = diff >>> shift_amt;
    assign low_run_inc = low_run_mem[slot] + 8'd1;
    assign low_reload = low_run_inc >= low_reset_cnt_reg;

    always_comb
    begin
        if (ext(SCAN_RAW) + ext(neg_noise_th_reg) < ext(bl))
            zone = tbd_pkg::ZONE_LOW;
        else if (ext(SCAN_RAW) > ext(bl) + ext(noise_th_reg) && !auto_reset)
            zone = tbd_pkg::ZONE_HIGH;
        else
            zone = tbd_pkg::ZONE_INSIDE;
    end

    // ------------------------------------------------------------------
    // baseline and low-sample run
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            seeded_reg <= '0;
        else if (scan_take)
            seeded_reg[slot] <= 1'b1;
    end

    always_ff @(posedge CLK)
    begin
        if (scan_take)
        begin
            if (!seeded_reg[slot])
            begin
                baseline_mem[slot] <= SCAN_RAW;
                low_run_mem[slot] <= 8'd0;
            end
            else
            begin
                case (zone)
                    tbd_pkg::ZONE_INSIDE:
                    begin
                        baseline_mem[slot] <= RAW_W'(ext(bl) + filt_step);
                        low_run_mem[slot] <= 8'd0;
                    end
                    tbd_pkg::ZONE_HIGH: low_run_mem[slot] <= 8'd0;
                    tbd_pkg::ZONE_LOW:
                    begin
                        if (low_reload)
                        begin
                            baseline_mem[slot] <= SCAN_RAW;
                            low_run_mem[slot] <= 8'd0;
                        end
                        else
                            low_run_mem[slot] <= low_run_inc;
                    end
                    default: low_run_mem[slot] <= 8'd0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // signal selection: direct or median of three frequencies
    // ------------------------------------------------------------------
    logic signed [EW-1:0] cur_diff;
    logic signed [EW-1:0] eval_signal;
    logic eval_now;

    // an unseeded slot has signal zero on its seeding scan
    assign cur_diff = seeded_reg[slot] ? diff : '0;
    // the median waits for the last frequency so all three are current
    assign eval_now = scan_take && (!multi_freq || SCAN_FREQ == 2'd2);

    always_comb
    begin
        if (multi_freq)
            eval_signal = median3(diff_mem[slot_of(SCAN_SENSOR, 2'd0)],
                diff_mem[slot_of(SCAN_SENSOR, 2'd1)], cur_diff);
        else
            eval_signal = cur_diff;
    end

    always_ff @(posedge CLK)
    begin
        if (scan_take)
            diff_mem[slot] <= cur_diff;
    end

    // ------------------------------------------------------------------
    // touch state with hysteresis and debounce
    // ------------------------------------------------------------------
    logic above_on;
    logic below_off;
    logic [7:0] deb_inc;

    assign above_on = eval_signal >= ext(finger_th_reg) + ext(hyst_reg);
    // hysteresis below threshold relies on software ordering them
    assign below_off = eval_signal <= ext(finger_th_reg) - ext(hyst_reg);
    assign deb_inc = deb_cnt_mem[SCAN_SENSOR] + 8'd1;

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            on_reg <= '0;
            for (int i = 0; i < NUM_SENSORS; i++)
                deb_cnt_mem[i] <= 8'd0;
        end
        else if (eval_now)
        begin
            if (above_on)
            begin
                if (deb_inc >= debounce_reg)
                    on_reg[SCAN_SENSOR] <= 1'b1;
                if (deb_cnt_mem[SCAN_SENSOR] != 8'hff)
                    deb_cnt_mem[SCAN_SENSOR] <= deb_inc;
            end
            else if (below_off)
            begin
                on_reg[SCAN_SENSOR] <= 1'b0;
                deb_cnt_mem[SCAN_SENSOR] <= 8'd0;
            end
            else
                // between limits: state kept, run of ON scans broken
                deb_cnt_mem[SCAN_SENSOR] <= 8'd0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            result_valid_reg <= 1'b0;
            result_sensor_reg <= '0;
            result_signal_reg <= '0;
        end
        else
        begin
            result_valid_reg <= eval_now;
            if (eval_now)
            begin
                result_sensor_reg <= SCAN_SENSOR;
                result_signal_reg <= (RAW_W + 1)'(eval_signal);
            end
        end
    end

    assign RESULT_VALID = result_valid_reg;
    assign RESULT_SENSOR = result_sensor_reg;
    assign RESULT_SIGNAL = result_signal_reg;
    assign SENSOR_ON = on_reg;

    // ------------------------------------------------------------------
    // apb slave: zero wait states, read data captured in setup phase
    // ------------------------------------------------------------------
    logic apb_wr;
    logic apb_setup;
    logic mapped;
    logic [IW-1:0] rd_slot;
    logic [31:0] rd_value;

    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_setup = PSEL && !PENABLE;
    assign rd_slot = slot_of(sel_sensor_reg, sel_freq_reg);

    always_comb
    begin
        mapped = 1'b1;
        rd_value = 32'h0000_0000;
        case (PADDR)
            tbd_pkg::OFF_CTRL: rd_value = ctrl_reg;
            tbd_pkg::OFF_FINGER_TH: rd_value = 32'(finger_th_reg);
            tbd_pkg::OFF_HYST: rd_value = 32'(hyst_reg);
            tbd_pkg::OFF_NOISE_TH: rd_value = 32'(noise_th_reg);
            tbd_pkg::OFF_NEG_NOISE_TH: rd_value = 32'(neg_noise_th_reg);
            tbd_pkg::OFF_LOW_RESET_CNT: rd_value = 32'(low_reset_cnt_reg);
            tbd_pkg::OFF_DEBOUNCE: rd_value = 32'(debounce_reg);
            tbd_pkg::OFF_SENSOR_SEL:
                rd_value = 32'(sel_sensor_reg) | (32'(sel_freq_reg) << tbd_pkg::SEL_FREQ_LSB);
            tbd_pkg::OFF_TOUCH_STATUS: rd_value = 32'(on_reg);
            tbd_pkg::OFF_BASELINE_RD: rd_value = 32'(baseline_mem[rd_slot]);
            tbd_pkg::OFF_SIGNAL_RD: rd_value = 32'(signed'(diff_mem[rd_slot]));
            tbd_pkg::OFF_LOW_RUN_RD: rd_value = 32'(low_run_mem[rd_slot]);
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            prdata_reg <= 32'h0000_0000;
        else if (apb_setup && !PWRITE)
            prdata_reg <= rd_value;
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ctrl_reg <= tbd_pkg::RST_CTRL;
            finger_th_reg <= RAW_W'(tbd_pkg::RST_FINGER_TH);
            hyst_reg <= RAW_W'(tbd_pkg::RST_HYST);
            noise_th_reg <= RAW_W'(tbd_pkg::RST_NOISE_TH);
            neg_noise_th_reg <= RAW_W'(tbd_pkg::RST_NEG_NOISE_TH);
            low_reset_cnt_reg <= tbd_pkg::RST_LOW_RESET_CNT;
            debounce_reg <= tbd_pkg::RST_DEBOUNCE;
            sel_sensor_reg <= '0;
            sel_freq_reg <= 2'd0;
        end
        else if (apb_wr)
        begin
            case (PADDR)
                tbd_pkg::OFF_CTRL: ctrl_reg <= PWDATA & 32'h0000_00f3;
                tbd_pkg::OFF_FINGER_TH: finger_th_reg <= PWDATA[RAW_W-1:0];
                tbd_pkg::OFF_HYST: hyst_reg <= PWDATA[RAW_W-1:0];
                tbd_pkg::OFF_NOISE_TH: noise_th_reg <= PWDATA[RAW_W-1:0];
                tbd_pkg::OFF_NEG_NOISE_TH: neg_noise_th_reg <= PWDATA[RAW_W-1:0];
                tbd_pkg::OFF_LOW_RESET_CNT: low_reset_cnt_reg <= PWDATA[7:0];
                tbd_pkg::OFF_DEBOUNCE: debounce_reg <= PWDATA[7:0];
                tbd_pkg::OFF_SENSOR_SEL:
                begin
                    sel_sensor_reg <= PWDATA[SW-1:0];
                    sel_freq_reg <= PWDATA[tbd_pkg::SEL_FREQ_LSB +: 2];
                end
                default: ;
            endcase
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;

endmodule : tbd_touch_baseline

// ---- inc/tbd_pkg.sv ----
/*
 * Constants shared by the touch baseline detector: register map, field
 * positions, reset values and sample zone enumeration.
 * Assumes a 32-bit APB register bus with word-aligned byte addresses.
 */
package tbd_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_FINGER_TH = 12'h004;
    localparam logic [11:0] OFF_HYST = 12'h008;
    localparam logic [11:0] OFF_NOISE_TH = 12'h00c;
    localparam logic [11:0] OFF_NEG_NOISE_TH = 12'h010;
    localparam logic [11:0] OFF_LOW_RESET_CNT = 12'h014;
    localparam logic [11:0] OFF_DEBOUNCE = 12'h018;
    localparam logic [11:0] OFF_SENSOR_SEL = 12'h01c;
    localparam logic [11:0] OFF_TOUCH_STATUS = 12'h020;
    localparam logic [11:0] OFF_BASELINE_RD = 12'h024;
    localparam logic [11:0] OFF_SIGNAL_RD = 12'h028;
    localparam logic [11:0] OFF_LOW_RUN_RD = 12'h02c;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_AUTO_RESET_BIT = 0;
    localparam int CTRL_MULTI_FREQ_BIT = 1;
    localparam int CTRL_SHIFT_LSB = 4;
    localparam int CTRL_SHIFT_W = 4;
    localparam int SEL_FREQ_LSB = 8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_CTRL = 32'h0000_0020;
    localparam logic [15:0] RST_FINGER_TH = 16'h0064;
    localparam logic [15:0] RST_HYST = 16'h000a;
    localparam logic [15:0] RST_NOISE_TH = 16'h0028;
    localparam logic [15:0] RST_NEG_NOISE_TH = 16'h0028;
    localparam logic [7:0] RST_LOW_RESET_CNT = 8'h1e;
    localparam logic [7:0] RST_DEBOUNCE = 8'h03;

    // number of sense clock frequencies in multi-frequency mode
    localparam int NUM_FREQ = 3;

    typedef enum logic [1:0] {
        ZONE_INSIDE,
        ZONE_HIGH,
        ZONE_LOW
    } tbd_zone_e;

endpackage : tbd_pkg

// ---- tb/tbd_chk.sv ----
/* port checker for the touch baseline detector.
   assumes config changes only through apb writes seen on its ports. */
`timescale 1ns/1ps
module tbd_chk #(
    parameter int NUM_SENSORS = 4,
    parameter int RAW_W = 16
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic SCAN_VALID,
    input wire logic [$clog2(NUM_SENSORS)-1:0] SCAN_SENSOR,
    input wire logic [1:0] SCAN_FREQ,
    input wire logic RESULT_VALID,
    input wire logic [$clog2(NUM_SENSORS)-1:0] RESULT_SENSOR,
    input wire logic signed [RAW_W:0] RESULT_SIGNAL,
    input wire logic [NUM_SENSORS-1:0] SENSOR_ON,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA
);
    // ----
    // shadow of config, so limits follow software
    // ----
    logic mf_reg;
    logic [15:0] fth_reg;
    logic [15:0] hyst_reg;
    logic [NUM_SENSORS-1:0] on_reg;
    logic wr;
    logic signed [17:0] on_lim;
    logic signed [17:0] off_lim;
    assign wr = PSEL && PENABLE && PWRITE;
    assign on_lim = $signed({2'b00, fth_reg}) + $signed({2'b00, hyst_reg});
    assign off_lim = $signed({2'b00, fth_reg}) - $signed({2'b00, hyst_reg});
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            mf_reg <= 1'b0;
            fth_reg <= tbd_pkg::RST_FINGER_TH;
            hyst_reg <= tbd_pkg::RST_HYST;
        end
        else if (wr)
        begin
            if (PADDR == tbd_pkg::OFF_CTRL)
                mf_reg <= PWDATA[tbd_pkg::CTRL_MULTI_FREQ_BIT];
            if (PADDR == tbd_pkg::OFF_FINGER_TH)
                fth_reg <= PWDATA[15:0];
            if (PADDR == tbd_pkg::OFF_HYST)
                hyst_reg <= PWDATA[15:0];
        end
    end
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            on_reg <= '0;
        else
            on_reg <= SENSOR_ON;
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    sequence s_result;
        SCAN_VALID ##1 RESULT_VALID;
    endsequence
    a_single_result: assert property (SCAN_VALID && SCAN_FREQ == 2'd0
        && !mf_reg |=> RESULT_VALID)
        else $error("single scan gave no result");
    a_median_result: assert property (SCAN_VALID && SCAN_FREQ == 2'd2
        && mf_reg |=> RESULT_VALID)
        else $error("third frequency gave no result");
    a_partial_quiet: assert property (SCAN_VALID && SCAN_FREQ != 2'd2
        && mf_reg |=> !RESULT_VALID)
        else $error("result before all three frequencies");
    a_freq_refused: assert property (SCAN_VALID && SCAN_FREQ != 2'd0
        && !mf_reg |=> !RESULT_VALID)
        else $error("ignored frequency gave a result");
    a_idle_quiet: assert property (!SCAN_VALID |=> !RESULT_VALID)
        else $error("result without a scan");
    a_sensor_echo: assert property (s_result |-> RESULT_SENSOR == $past(SCAN_SENSOR))
        else $error("result names the wrong sensor");
    a_state_cause: assert property (SENSOR_ON != on_reg |-> RESULT_VALID)
        else $error("state changed without evaluation");
    a_on_thresh: assert property (RESULT_VALID && SENSOR_ON[RESULT_SENSOR]
        && !on_reg[RESULT_SENSOR] |-> RESULT_SIGNAL >= on_lim)
        else $error("sensor on below upper limit");
    a_off_thresh: assert property (RESULT_VALID && RESULT_SIGNAL <= off_lim
        |-> !SENSOR_ON[RESULT_SENSOR])
        else $error("sensor on at or below lower limit");
    a_hold_between: assert property (RESULT_VALID && RESULT_SIGNAL > off_lim
        && RESULT_SIGNAL < on_lim |-> SENSOR_ON == on_reg)
        else $error("state changed between limits");
endmodule : tbd_chk
bind tbd_touch_baseline tbd_chk #(.NUM_SENSORS(NUM_SENSORS), .RAW_W(RAW_W)) u_tbd_chk (
    .CLK(CLK), .RESETN(RESETN), .SCAN_VALID(SCAN_VALID), .SCAN_SENSOR(SCAN_SENSOR),
    .SCAN_FREQ(SCAN_FREQ), .RESULT_VALID(RESULT_VALID), .RESULT_SENSOR(RESULT_SENSOR),
    .RESULT_SIGNAL(RESULT_SIGNAL), .SENSOR_ON(SENSOR_ON), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA));

// ---- tb/tbd_scan_src.sv ----
/* scan front end model: one raw count result per call.
   assumes its caller spaces calls; between results lines show inverted values. */
`timescale 1ns/1ps
module tbd_scan_src #(
    parameter int NUM_SENSORS = 4
) (
    input wire logic CLK,
    output logic SCAN_VALID,
    output logic [$clog2(NUM_SENSORS)-1:0] SCAN_SENSOR,
    output logic [1:0] SCAN_FREQ,
    output logic [15:0] SCAN_RAW
);
    initial
    begin
        SCAN_VALID = 1'b0;
        SCAN_SENSOR = '0;
        SCAN_FREQ = 2'd0;
        SCAN_RAW = 16'h0000;
    end
    task automatic send(input int s, input int f, input int raw, input int gap);
        repeat (gap) @(posedge CLK);
        @(posedge CLK);
        SCAN_VALID <= 1'b1;
        SCAN_SENSOR <= s[$clog2(NUM_SENSORS)-1:0];
        SCAN_FREQ <= f[1:0];
        SCAN_RAW <= raw[15:0];
        @(posedge CLK);
        SCAN_VALID <= 1'b0;
        SCAN_SENSOR <= ~s[$clog2(NUM_SENSORS)-1:0];
        SCAN_FREQ <= ~f[1:0];
        SCAN_RAW <= ~raw[15:0];
    endtask : send
endmodule : tbd_scan_src

// ---- tb/tbd_touch_baseline_tb.sv ----
/* self-checking bench for the touch baseline detector.
   assumes the scan source model and the bound port checker. */
`timescale 1ns/1ps
module tbd_touch_baseline_tb;
    logic CLK;
    logic RESETN;
    logic SCAN_VALID;
    logic [1:0] SCAN_SENSOR;
    logic [1:0] SCAN_FREQ;
    logic [15:0] SCAN_RAW;
    logic RESULT_VALID;
    logic [1:0] RESULT_SENSOR;
    logic signed [16:0] RESULT_SIGNAL;
    logic [3:0] SENSOR_ON;
    logic PSEL;
    logic PENABLE;
    logic PWRITE;
    logic [11:0] PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int checked = 0;
    int seed = 32'h62dfbe77;
    int bl [4][3];
    bit seeded [4][3];
    int run [4][3];
    int dif [4][3];
    bit on [4];
    int db [4];
    int fth = 100;
    int hyst = 10;
    int nt = 40;
    int nnt = 40;
    int lrc = 30;
    int dbc = 3;
    int shift = 2;
    bit ar = 0;
    bit mf = 0;
    int offs [8] = '{120, 120, 100, 120, 120, 120, 100, 80};
    logic [31:0] rst_tab [7] = '{tbd_pkg::RST_CTRL, 32'(tbd_pkg::RST_FINGER_TH),
        32'(tbd_pkg::RST_HYST), 32'(tbd_pkg::RST_NOISE_TH), 32'(tbd_pkg::RST_NEG_NOISE_TH),
        32'(tbd_pkg::RST_LOW_RESET_CNT), 32'(tbd_pkg::RST_DEBOUNCE)};
    tbd_touch_baseline #(.NUM_SENSORS(4), .RAW_W(16)) u_tbd_touch_baseline (
        .CLK(CLK), .RESETN(RESETN), .SCAN_VALID(SCAN_VALID), .SCAN_SENSOR(SCAN_SENSOR),
        .SCAN_FREQ(SCAN_FREQ), .SCAN_RAW(SCAN_RAW), .RESULT_VALID(RESULT_VALID),
        .RESULT_SENSOR(RESULT_SENSOR), .RESULT_SIGNAL(RESULT_SIGNAL), .SENSOR_ON(SENSOR_ON),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
    tbd_scan_src #(.NUM_SENSORS(4)) u_tbd_scan_src (.CLK(CLK), .SCAN_VALID(SCAN_VALID),
        .SCAN_SENSOR(SCAN_SENSOR), .SCAN_FREQ(SCAN_FREQ), .SCAN_RAW(SCAN_RAW));
    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    // ----
    // tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1)
            @(posedge CLK);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    function automatic int med(input int a, input int b, input int c);
        if ((a - b) * (a - c) <= 0)
            return a;
        if ((b - a) * (b - c) <= 0)
            return b;
        return c;
    endfunction : med
    // model first, then the scan; result is looked at in its one valid cycle
    task automatic scan(input int s, input int f, input int r);
        int d;
        int sig;
        bit ev;
        ev = !(f == 3 || (!mf && f != 0));
        if (ev)
        begin
            d = 0;
            if (!seeded[s][f])
            begin
                bl[s][f] = r;
                seeded[s][f] = 1;
            end
            else
            begin
                d = r - bl[s][f];
                if (r + nnt < bl[s][f])
                begin
                    run[s][f]++;
                    if (run[s][f] >= lrc)
                    begin
                        bl[s][f] = r;
                        run[s][f] = 0;
                    end
                end
                else
                begin
                    run[s][f] = 0;
                    if (ar || r <= bl[s][f] + nt)
                        bl[s][f] += d >>> shift;
                end
            end
            dif[s][f] = d;
            sig = mf ? med(dif[s][0], dif[s][1], d) : d;
            ev = !mf || f == 2;
            if (ev && sig >= fth + hyst)
            begin
                db[s]++;
                if (db[s] >= dbc)
                    on[s] = 1;
            end
            else if (ev)
            begin
                db[s] = 0;
                if (sig <= fth - hyst)
                    on[s] = 0;
            end
        end
        u_tbd_scan_src.send(s, f, r, $random(seed) & 1);
        #1;
        check(RESULT_VALID, ev);
        if (ev)
        begin
            check(32'(RESULT_SIGNAL), sig);
            check(SENSOR_ON[s], on[s]);
        end
    endtask : scan
    initial
    begin
        repeat (20000) @(posedge CLK);
        bad_count++;
        give_verdict();
    end
    initial
    begin
        RESETN = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h0000_0000;
        repeat (8) @(posedge CLK);
        RESETN <= 1'b1;
        foreach (rst_tab[i])
        begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check(rd, rst_tab[i]);
        end
        apb(1'b1, 12'h030, 32'hffff_ffff);
        apb(1'b0, 12'h030, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000);
        lrc = 5;
        apb(1'b1, tbd_pkg::OFF_LOW_RESET_CNT, 32'(lrc));
        scan(0, 0, 1200);
        repeat (4) scan(0, 0, 1000);
        scan(0, 0, 1200);
        repeat (6) scan(0, 0, 1000);
        apb(1'b1, tbd_pkg::OFF_SENSOR_SEL, 32'h0);
        apb(1'b0, tbd_pkg::OFF_BASELINE_RD, 32'h0);
        check(rd, bl[0][0]);
        repeat (24) scan($random(seed) & 3, 0, 1000 + $random(seed) % 60);
        foreach (offs[i]) scan(1, 0, bl[1][0] + offs[i]);
        dbc = 0;
        apb(1'b1, tbd_pkg::OFF_DEBOUNCE, 32'h0);
        scan(1, 0, bl[1][0] + 120);
        scan(1, 0, bl[1][0] + 80);
        {ar, shift} = {1'b1, 32'd3};
        apb(1'b1, tbd_pkg::OFF_CTRL, 32'h31);
        repeat (4) scan(1, 0, bl[1][0] + 200);
        scan(1, 0, bl[1][0] - 100);
        {ar, mf, shift} = {1'b0, 1'b1, 32'd2};
        apb(1'b1, tbd_pkg::OFF_CTRL, 32'h22);
        repeat (6)
            for (int f = 0; f < 4; f++) scan(2, f, 1500 + $random(seed) % 300);
        for (int f = 0; f < 3; f++) scan(2, f, bl[2][f] + (f == 2 ? 50 : 150));
        mf = 0;
        apb(1'b1, tbd_pkg::OFF_CTRL, 32'h20);
        scan(3, 1, 1000);
        give_verdict();
    end
endmodule : tbd_touch_baseline_tb
